/* core/bod_pkg.sv */
/*
  Shared constants and types for the branch and operand decode block.
  Assumes a 32-bit instruction word and one synchronous clock domain.
*/
package bod_pkg;
  localparam int unsigned WORD_W      = 32;
  localparam int unsigned SHORT_OFF_W = 16;
  localparam int unsigned LONG_OFF_W  = 26;
  localparam int unsigned VEC_W       = 9;
  localparam int unsigned VBASE_W     = 20;
  // Condition match field position within the instruction
  localparam int unsigned COND_HI     = 25;
  localparam int unsigned COND_LO     = 21;
  // Named condition encodings for bits 25..21
  localparam logic [4:0] COND_EQ0 = 5'h02;
  localparam logic [4:0] COND_NE0 = 5'h0D;
  localparam logic [4:0] COND_GT0 = 5'h01;
  localparam logic [4:0] COND_LT0 = 5'h0C;
  localparam logic [4:0] COND_GE0 = 5'h03;
  localparam logic [4:0] COND_LE0 = 5'h0E;
  // Reset values
  localparam logic [31:0] RESET_PTR = 32'h0000_0000;
  // Bounds-check vector number (plain default)
  localparam logic [8:0]  BOUNDS_VEC = 9'h005;
  // Full field width when the width operand is zero
  localparam logic [5:0]  FULL_WIDTH = 6'h20;

  typedef enum logic [3:0] {
    BOD_OP_NONE = 4'b0000,
    BOD_OP_BB0  = 4'b0001,
    BOD_OP_BB1  = 4'b0010,
    BOD_OP_BCND = 4'b0011,
    BOD_OP_TBND = 4'b0100,
    BOD_OP_BR   = 4'b0101,
    BOD_OP_BSR  = 4'b0110,
    BOD_OP_JMP  = 4'b0111
  } bod_op_t;

  typedef enum logic [2:0] {
    BOD_SZ_WORD = 3'b000,
    BOD_SZ_BYTE = 3'b001,
    BOD_SZ_BU   = 3'b010,
    BOD_SZ_HALF = 3'b011,
    BOD_SZ_HU   = 3'b100,
    BOD_SZ_DBL  = 3'b101
  } bod_size_t;

  typedef enum logic [1:0] {
    BOD_ST_RUN   = 2'b00,
    BOD_ST_DELAY = 2'b01,
    BOD_ST_TRAP  = 2'b10
  } bod_state_t;
endpackage

/* core/bod_qual_if.sv */
/*
  Carries decoded operand qualifiers from the qualifier decoder to the top.
  Assumes both ends share the top module's clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface bod_qual_if;
  import bod_pkg::*;
  logic            complement;
  logic            upper_half;
  logic            carry_in_option;
  logic            carry_out_option;
  bod_size_t       mem_size;
  logic            mem_signed;
  logic            user_space;
  logic [5:0]      width;
  logic [2:0]      fp_double;
  logic [4:0]      store_src;
  modport producer (output complement, upper_half, carry_in_option, carry_out_option,
                    mem_size, mem_signed, user_space, width, fp_double, store_src);
  modport consumer (input complement, upper_half, carry_in_option, carry_out_option,
                    mem_size, mem_signed, user_space, width, fp_double, store_src);
endinterface
`default_nettype wire

/* core/bod_qual_decode.sv */
/*
  Combinational decoder for operand qualifier fields.
  Assumes qualifier fields arrive already separated from the instruction.
*/
`timescale 1ns/1ps
`default_nettype none
module bod_qual_decode
  import bod_pkg::*;
(
  input  wire logic       sel_complement,
  input  wire logic       sel_upper,
  input  wire logic [1:0] sel_carry,
  input  wire logic [2:0] sel_size,
  input  wire logic       sel_user,
  input  wire logic       supervisor,
  input  wire logic [4:0] field_width,
  input  wire logic [2:0] sel_fp_double,
  input  wire logic [4:0] dest_field,
  bod_qual_if.producer    q
);
  // Qualifier decode
  always_comb begin
    q.complement       = sel_complement;
    q.upper_half       = sel_upper;
    q.carry_in_option  = sel_carry[0];
    q.carry_out_option = sel_carry[1];
    q.user_space       = sel_user & supervisor;
    q.width            = (field_width == 5'h00) ? FULL_WIDTH
                                                : {1'b0, field_width};
    q.fp_double        = sel_fp_double;
    q.store_src        = dest_field;
    case (sel_size)
      3'h1:    q.mem_size = BOD_SZ_BYTE;
      3'h2:    q.mem_size = BOD_SZ_BU;
      3'h3:    q.mem_size = BOD_SZ_HALF;
      3'h4:    q.mem_size = BOD_SZ_HU;
      3'h5:    q.mem_size = BOD_SZ_DBL;
      default: q.mem_size = BOD_SZ_WORD;
    endcase
    q.mem_signed = !(q.mem_size == BOD_SZ_BU || q.mem_size == BOD_SZ_HU);
  end
endmodule
`default_nettype wire

/* core/bod_branch_unit.sv */
/*
  Branch, bounds-check and operand qualifier decode for the execute stage.
  Assumes the register file supplies operands and accepts the pointer outputs.
*/
`timescale 1ns/1ps
`default_nettype none
module bod_branch_unit
  import bod_pkg::*;
(
  input  wire logic                      clk,
  input  wire logic                      reset_n,
  input  wire logic                      instr_valid,
  input  wire bod_pkg::bod_op_t          op,
  input  wire logic                      delay_option,
  input  wire logic [4:0]                bit_select_field,
  input  wire logic [4:0]                condition_match_field,
  input  wire logic [15:0]               short_branch_offset,
  input  wire logic [25:0]               long_branch_offset,
  input  wire logic [15:0]               unsigned_immediate,
  input  wire logic [15:0]               immediate_index,
  input  wire logic [31:0]               first_source_reg,
  input  wire logic [31:0]               second_source_reg,
  input  wire logic [31:0]               execute_pointer,
  input  wire logic [19:0]               vector_base_reg,
  input  wire logic                      carry_flag,
  input  wire logic                      sel_complement,
  input  wire logic                      sel_upper,
  input  wire logic [1:0]                sel_carry,
  input  wire logic [2:0]                sel_size,
  input  wire logic                      sel_user,
  input  wire logic                      supervisor,
  input  wire logic [4:0]                field_width,
  input  wire logic [2:0]                sel_fp_double,
  input  wire logic [4:0]                dest_field,
  output logic [31:0]                    fetch_pointer,
  output logic                           branch_taken,
  output logic                           delay_slot,
  output logic                           trap_taken,
  output logic                           exception_start,
  output logic [31:0]                    link_value,
  output logic [31:0]                    operand_b,
  output logic [31:0]                    mem_address,
  output logic                           carry_in_used,
  output logic                           carry_out_update,
  output bod_pkg::bod_size_t             mem_size,
  output logic                           mem_signed,
  output logic                           user_space_access,
  output logic [5:0]                     field_width_eff,
  output logic [2:0]                     fp_double,
  output logic [4:0]                     store_src_reg
);
  import bod_pkg::*;

  typedef struct packed {
    bod_state_t  state;
    logic [31:0] fetch_pointer;
    logic [31:0] pending_target;
    logic        branch_taken;
    logic        delay_slot;
    logic        trap_taken;
    logic        exception_start;
    logic [31:0] link_value;
    logic [31:0] operand_b;
    logic [31:0] mem_address;
    logic        carry_in_used;
    logic        carry_out_update;
    bod_size_t   mem_size;
    logic        mem_signed;
    logic        user_space_access;
    logic [5:0]  field_width_eff;
    logic [2:0]  fp_double;
    logic [4:0]  store_src_reg;
  } bod_regs_t;

  // Registered state and its next value
  bod_regs_t st_ff;
  bod_regs_t nxt_st;

  // Qualifier bundle from the decoder
  bod_qual_if q ();

  // Sign-extend a word offset shifted left by two
  function automatic logic [31:0] bod_short_target(input logic [31:0] base,
                                                   input logic [15:0] off);
    logic [31:0] ext;
    ext = {{14{off[15]}}, off, 2'b00};
    bod_short_target = base + ext;
  endfunction

  // Same for the long displacement
  function automatic logic [31:0] bod_long_target(input logic [31:0] base,
                                                  input logic [25:0] off);
    logic [31:0] ext;
    ext = {{4{off[25]}}, off, 2'b00};
    bod_long_target = base + ext;
  endfunction

  // Qualifier decoding
  bod_qual_decode u_qual (
    .sel_complement (sel_complement),
    .sel_upper      (sel_upper),
    .sel_carry      (sel_carry),
    .sel_size       (sel_size),
    .sel_user       (sel_user),
    .supervisor     (supervisor),
    .field_width    (field_width),
    .sel_fp_double  (sel_fp_double),
    .dest_field     (dest_field),
    .q              (q.producer)
  );

  // Decode helpers for the next-state logic
  logic        sign_flag;
  logic        zero_flag;
  logic [3:0]  cond_hits;
  logic        cond_true;
  logic        bit_value;
  logic        bound_fail;
  logic [31:0] seq_next;
  logic [31:0] trap_target;
  logic [31:0] opb_raw;

  // Condition flags and tests
  always_comb begin
    sign_flag  = first_source_reg[31];
    zero_flag  = ~|first_source_reg[30:0];
    cond_hits  = {sign_flag  &  zero_flag,   // Bit 24: most negative
                  sign_flag  & ~zero_flag,   // Bit 23: below zero
                  ~sign_flag &  zero_flag,   // Bit 22: zero
                  ~sign_flag & ~zero_flag};  // Bit 21: above zero
    // Bit 25 of the match field is deliberately left out
    cond_true  = |(condition_match_field[3:0] & cond_hits);
    bit_value  = first_source_reg[bit_select_field];
    bound_fail = first_source_reg > {16'h0000, unsigned_immediate};
    seq_next   = st_ff.fetch_pointer + 32'h0000_0004;
    trap_target = {vector_base_reg, 3'b000, 9'h000}
                  | {20'h00000, BOUNDS_VEC, 3'b000};
  end

  // Second operand with complement and upper-half options
  always_comb begin
    opb_raw = (op == BOD_OP_NONE && sel_upper)
              ? {unsigned_immediate, 16'h0000} : second_source_reg;
    if (q.complement) begin
      opb_raw = ~opb_raw;
    end
  end

  // Next-state logic
  always_comb begin
    // Pulses default low; qualifiers follow inputs
    nxt_st                 = st_ff;
    nxt_st.branch_taken    = 1'b0;
    nxt_st.trap_taken      = 1'b0;
    nxt_st.exception_start = 1'b0;
    nxt_st.delay_slot      = 1'b0;
    nxt_st.operand_b       = opb_raw;
    nxt_st.mem_address     = first_source_reg + {16'h0000, immediate_index};
    nxt_st.carry_in_used   = q.carry_in_option & carry_flag;
    nxt_st.carry_out_update = q.carry_out_option;
    nxt_st.mem_size        = q.mem_size;
    nxt_st.mem_signed      = q.mem_signed;
    nxt_st.user_space_access = q.user_space;
    nxt_st.field_width_eff = q.width;
    nxt_st.fp_double       = q.fp_double;
    nxt_st.store_src_reg   = q.store_src;
    // Instructions are only honoured in RUN
    case (st_ff.state)
      BOD_ST_RUN: begin
        if (instr_valid) begin
          logic        take;
          logic [31:0] tgt;
          take = 1'b0;
          tgt  = seq_next;
          case (op)
            // Branch when the tested bit is clear
            BOD_OP_BB0: begin
              take = ~bit_value;
              tgt  = bod_short_target(execute_pointer, short_branch_offset);
            end
            // Branch when the tested bit is set
            BOD_OP_BB1: begin
              take = bit_value;
              tgt  = bod_short_target(execute_pointer, short_branch_offset);
            end
            // Branch on any enabled condition
            BOD_OP_BCND: begin
              take = cond_true;
              tgt  = bod_short_target(execute_pointer, short_branch_offset);
            end
            // Always branch, long displacement
            BOD_OP_BR, BOD_OP_BSR: begin
              take = 1'b1;
              tgt  = bod_long_target(execute_pointer, long_branch_offset);
            end
            // Register target, forced to a word address
            BOD_OP_JMP: begin
              take = 1'b1;
              tgt  = {second_source_reg[31:2], 2'b00};
            end
            // Not a flow change: fall through
            default: begin
              take = 1'b0;
            end
          endcase
          // Return address skips the delay slot when one is used
          if (op == BOD_OP_BSR) begin
            nxt_st.link_value = execute_pointer + (delay_option ? 32'h0000_0008
                                                                : 32'h0000_0004);
          end
          // A trap outranks any branch and has its own target
          if (op == BOD_OP_TBND && bound_fail) begin
            nxt_st.fetch_pointer   = trap_target;
            nxt_st.trap_taken      = 1'b1;
            nxt_st.state           = BOD_ST_TRAP;
          end else if (take && delay_option) begin
            // Delay slot: the next sequential word issues first
            nxt_st.fetch_pointer   = seq_next;
            nxt_st.pending_target  = tgt;
            nxt_st.delay_slot      = 1'b1;
            nxt_st.state           = BOD_ST_DELAY;
          end else if (take) begin
            nxt_st.fetch_pointer   = tgt;
            nxt_st.branch_taken    = 1'b1;
          end else begin
            // False test or plain instruction: next word
            nxt_st.fetch_pointer   = seq_next;
          end
        end
      end
      // Delay slot has issued; redirect to the saved target
      BOD_ST_DELAY: begin
        nxt_st.fetch_pointer = st_ff.pending_target;
        nxt_st.branch_taken  = 1'b1;
        nxt_st.state         = BOD_ST_RUN;
      end
      // Vector loaded; exception handling starts now
      BOD_ST_TRAP: begin
        nxt_st.exception_start = 1'b1;
        nxt_st.state           = BOD_ST_RUN;
      end
      // Unused encoding recovers to RUN
      default: begin
        nxt_st.state = BOD_ST_RUN;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_ff <= '0;
      st_ff.fetch_pointer <= RESET_PTR;
      st_ff.state <= BOD_ST_RUN;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from the state register
  assign fetch_pointer     = st_ff.fetch_pointer;
  assign branch_taken      = st_ff.branch_taken;
  assign delay_slot        = st_ff.delay_slot;
  assign trap_taken        = st_ff.trap_taken;
  assign exception_start   = st_ff.exception_start;
  assign link_value        = st_ff.link_value;
  assign operand_b         = st_ff.operand_b;
  assign mem_address       = st_ff.mem_address;
  assign carry_in_used     = st_ff.carry_in_used;
  assign carry_out_update  = st_ff.carry_out_update;
  assign mem_size          = st_ff.mem_size;
  assign mem_signed        = st_ff.mem_signed;
  assign user_space_access = st_ff.user_space_access;
  assign field_width_eff   = st_ff.field_width_eff;
  assign fp_double         = st_ff.fp_double;
  assign store_src_reg     = st_ff.store_src_reg;
endmodule
`default_nettype wire

/* verification/bod_code_gen.sv */
/*
  Code generator model: encodes named branch conditions into the match field.
  Assumes the bench picks the condition and may ask for a bad top bit.
*/
`timescale 1ns/1ps
`default_nettype none
module bod_code_gen
  import bod_pkg::*;
(
  input  wire logic [2:0] cond_sel,
  input  wire logic       bad_top,
  output logic [4:0]      match_code
);
  // Named condition table, top bit set only on request
  always_comb begin
    case (cond_sel)
      3'h0: match_code = 5'h02;
      3'h1: match_code = 5'h0D;
      3'h2: match_code = 5'h01;
      3'h3: match_code = 5'h0C;
      3'h4: match_code = 5'h03;
      default: match_code = 5'h0E;
    endcase
    if (bad_top) begin
      match_code[4] = 1'b1;
    end
  end
endmodule
`default_nettype wire

/* verification/bod_branch_unit_assertions.sv */
/*
  Port checker for the branch unit.
  Assumes one clock, async active-low reset, outputs one cycle behind.
*/
`timescale 1ns/1ps
`default_nettype none
module bod_branch_chk
  import bod_pkg::*;
(
  input wire logic             clk,
  input wire logic             reset_n,
  input wire logic             instr_valid,
  input wire bod_pkg::bod_op_t op,
  input wire logic             delay_option,
  input wire logic [4:0]       bit_select_field,
  input wire logic [4:0]       condition_match_field,
  input wire logic [15:0]      short_branch_offset,
  input wire logic [25:0]      long_branch_offset,
  input wire logic [15:0]      unsigned_immediate,
  input wire logic [31:0]      first_source_reg,
  input wire logic [31:0]      second_source_reg,
  input wire logic [31:0]      execute_pointer,
  input wire logic [19:0]      vector_base_reg,
  input wire logic             sel_complement,
  input wire logic             sel_upper,
  input wire logic [4:0]       field_width,
  input wire logic [31:0]      fetch_pointer,
  input wire logic             branch_taken,
  input wire logic             delay_slot,
  input wire logic             trap_taken,
  input wire logic             exception_start,
  input wire logic [31:0]      operand_b,
  input wire logic [5:0]       field_width_eff
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Accepted instruction, condition flags and branch targets
  wire        take = instr_valid && !delay_slot && !trap_taken;
  wire        sgn  = first_source_reg[31];
  wire        zro  = ~|first_source_reg[30:0];
  wire        hit  = |(condition_match_field[3:0] & {sgn & zro, sgn & !zro, !sgn & zro, !sgn & !zro});
  wire        over = first_source_reg > {16'h0, unsigned_immediate};
  wire [31:0] s_tgt = execute_pointer + {{14{short_branch_offset[15]}}, short_branch_offset, 2'h0};
  wire [31:0] l_tgt = execute_pointer + {{4{long_branch_offset[25]}}, long_branch_offset, 2'h0};
  chk_bit_set_target: assert property (
    take && op == BOD_OP_BB1 && first_source_reg[bit_select_field] && !delay_option
    |=> branch_taken && fetch_pointer == $past(s_tgt)) else $error("bit set branch target wrong");
  chk_bit_clr_take: assert property (
    take && op == BOD_OP_BB0 && !first_source_reg[bit_select_field] && !delay_option
    |=> branch_taken) else $error("bit clear branch not taken");
  chk_cond_match: assert property (
    take && op == BOD_OP_BCND && !delay_option |=> branch_taken == $past(hit))
    else $error("condition branch decision wrong");
  chk_false_seq: assert property (
    take && op == BOD_OP_BCND && !hit |=> fetch_pointer == $past(fetch_pointer) + 32'h4)
    else $error("false test did not step by four");
  chk_bound_trap: assert property (
    take && op == BOD_OP_TBND && over
    |=> trap_taken && fetch_pointer == {$past(vector_base_reg), BOUNDS_VEC, 3'h0}
    ##1 exception_start) else $error("bounds trap sequence wrong");
  chk_bound_pass: assert property (
    take && op == BOD_OP_TBND && !over |=> !trap_taken ##1 !exception_start)
    else $error("bounds trap without cause");
  chk_long_target: assert property (
    take && (op == BOD_OP_BR || op == BOD_OP_BSR) && !delay_option
    |=> fetch_pointer == $past(l_tgt)) else $error("long branch target wrong");
  chk_delay_order: assert property (
    take && op == BOD_OP_BR && delay_option |=> delay_slot && !branch_taken
    ##1 branch_taken && fetch_pointer == $past(l_tgt, 2)) else $error("delayed branch order wrong");
  chk_width_zero: assert property (
    field_width == 5'h0 |=> field_width_eff == FULL_WIDTH) else $error("zero width not full");
  chk_complement_op: assert property (
    op == BOD_OP_NONE && sel_complement && !sel_upper |=> operand_b == ~$past(second_source_reg))
    else $error("complement operand wrong");
  cover property (take && op == BOD_OP_TBND ##1 trap_taken);
  cover property (delay_slot ##1 branch_taken);
  cover property (take && op == BOD_OP_BCND ##1 branch_taken);
endmodule
bind bod_branch_unit bod_branch_chk chk_u (
  .clk(clk), .reset_n(reset_n), .instr_valid(instr_valid), .op(op),
  .delay_option(delay_option), .bit_select_field(bit_select_field),
  .condition_match_field(condition_match_field),
  .short_branch_offset(short_branch_offset), .long_branch_offset(long_branch_offset),
  .unsigned_immediate(unsigned_immediate), .first_source_reg(first_source_reg),
  .second_source_reg(second_source_reg), .execute_pointer(execute_pointer),
  .vector_base_reg(vector_base_reg), .sel_complement(sel_complement),
  .sel_upper(sel_upper), .field_width(field_width), .fetch_pointer(fetch_pointer),
  .branch_taken(branch_taken), .delay_slot(delay_slot), .trap_taken(trap_taken),
  .exception_start(exception_start), .operand_b(operand_b),
  .field_width_eff(field_width_eff));
`default_nettype wire

/* verification/test_branch_operand_decode.sv */
/*
  Self-checking bench for the branch unit.
  Assumes inputs change on the falling edge and outputs lag one cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module test_branch_operand_decode;
  import bod_pkg::*;
  logic clk = 1'b0, reset_n = 1'b0, instr_valid = 1'b0, delay_option = 1'b0, carry_flag = 1'b1;
  logic sel_complement = 1'b0, sel_upper = 1'b0, sel_user = 1'b0, supervisor = 1'b0;
  logic bad_top = 1'b0;
  logic [2:0] cond_sel = 3'h0, sel_size = 3'h0, sel_fp_double = 3'h0;
  logic [1:0] sel_carry = 2'h0;
  logic [4:0] bit_select_field = 5'h0, field_width = 5'h1, dest_field = 5'h0;
  logic [15:0] short_branch_offset = 16'h0, unsigned_immediate = 16'h0, immediate_index = 16'h0;
  logic [25:0] long_branch_offset = 26'h0;
  logic [31:0] first_source_reg = 32'h0, second_source_reg = 32'h0, execute_pointer = 32'h0;
  logic [19:0] vector_base_reg = 20'h0;
  bod_op_t     op = BOD_OP_NONE;
  wire logic [4:0] condition_match_field;
  logic [31:0] fetch_pointer, link_value, operand_b, mem_address, efp;
  logic branch_taken, delay_slot, trap_taken, exception_start, carry_in_used, carry_out_update;
  logic mem_signed, user_space_access;
  logic [5:0] field_width_eff;
  logic [2:0] fp_double;
  logic [4:0] store_src_reg;
  bod_size_t  mem_size;
  int n_errors = 0;
  int checked = 0;
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_errors++; \
  $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end

  bod_branch_unit dut_u (.*);
  bod_code_gen gen_u (.cond_sel(cond_sel), .bad_top(bad_top), .match_code(condition_match_field));

  // Free-running 10 MHz clock
  always #50 clk = ~clk;

  // One idle cycle, then one instruction for one rising edge
  task automatic issue(bod_op_t o, logic dly);
    @(negedge clk);
    op = o;
    delay_option = dly;
    instr_valid = 1'b1;
    @(negedge clk);
    instr_valid = 1'b0;
  endtask

  // Expected outcome of a named condition, from signed semantics
  function automatic logic cond_exp(int c, logic signed [31:0] v);
    case (c)
      0: return v == 0;
      1: return v != 0;
      2: return v > 0;
      3: return v < 0;
      4: return v >= 0;
      default: return v <= 0;
    endcase
  endfunction

  task automatic t_bit();
    execute_pointer = 32'h0000_1000;
    short_branch_offset = 16'hFFFE;
    first_source_reg = 32'h8000_0000;
    bit_select_field = 5'h1F;
    issue(BOD_OP_BB1, 1'b0);
    `CHK(branch_taken, 1'b1)
    `CHK(fetch_pointer, 32'h0000_0FF8)
    bit_select_field = 5'h00;
    issue(BOD_OP_BB1, 1'b0);
    `CHK(branch_taken, 1'b0)
    `CHK(fetch_pointer, 32'h0000_0FFC)
    short_branch_offset = 16'h0010;
    issue(BOD_OP_BB0, 1'b0);
    efp = 32'h0000_1040;
    `CHK(fetch_pointer, efp)
    $display("bit test done");
  endtask

  task automatic t_cond();
    logic [31:0] vals [4] = '{32'h0, 32'h8000_0000, 32'h5, 32'hFFFF_FFFF};
    logic e;
    execute_pointer = 32'h0000_2000;
    short_branch_offset = 16'h0004;
    for (int b = 0; b < 2; b++) begin
      for (int c = 0; c < 6; c++) begin
        for (int v = 0; v < 4; v++) begin
          bad_top = b[0];
          cond_sel = c[2:0];
          first_source_reg = vals[v];
          e = cond_exp(c, vals[v]);
          issue(BOD_OP_BCND, 1'b0);
          efp = e ? 32'h0000_2010 : efp + 32'h4;
          `CHK(branch_taken, e)
          `CHK(fetch_pointer, efp)
        end
      end
    end
    bad_top = 1'b0;
    $display("condition test done");
  endtask

  task automatic t_trap();
    vector_base_reg = 20'hABCDE;
    unsigned_immediate = 16'h00FF;
    dest_field = 5'h0;
    first_source_reg = 32'h0000_00FF;
    issue(BOD_OP_TBND, 1'b0);
    efp += 32'h4;
    `CHK(trap_taken, 1'b0)
    `CHK(fetch_pointer, efp)
    first_source_reg = 32'h8000_0000;
    issue(BOD_OP_TBND, 1'b0);
    `CHK(trap_taken, 1'b1)
    `CHK(fetch_pointer, {20'hABCDE, BOUNDS_VEC, 3'h0})
    @(negedge clk);
    `CHK(exception_start, 1'b1)
    $display("bounds test done");
  endtask

  task automatic t_long();
    execute_pointer = 32'h0000_4000;
    long_branch_offset = 26'h3FF_FFFC;
    issue(BOD_OP_BR, 1'b0);
    `CHK(fetch_pointer, 32'h0000_3FF0)
    long_branch_offset = 26'h000_0100;
    issue(BOD_OP_BSR, 1'b0);
    `CHK(fetch_pointer, 32'h0000_4400)
    `CHK(link_value, 32'h0000_4004)
    issue(BOD_OP_BR, 1'b1);
    `CHK(delay_slot, 1'b1)
    `CHK(fetch_pointer, 32'h0000_4404)
    @(negedge clk);
    `CHK(branch_taken, 1'b1)
    `CHK(fetch_pointer, 32'h0000_4400)
    second_source_reg = 32'h0000_5003;
    issue(BOD_OP_JMP, 1'b0);
    `CHK(fetch_pointer, 32'h0000_5000)
    $display("long branch test done");
  endtask

  task automatic t_qual();
    op = BOD_OP_NONE;
    second_source_reg = 32'h1234_00FF;
    unsigned_immediate = 16'hBEEF;
    sel_complement = 1'b1;
    @(negedge clk);
    `CHK(operand_b, 32'hEDCB_FF00)
    sel_complement = 1'b0;
    sel_upper = 1'b1;
    @(negedge clk);
    `CHK(operand_b, 32'hBEEF_0000)
    sel_upper = 1'b0;
    for (int k = 0; k < 4; k++) begin
      sel_carry = k[1:0];
      @(negedge clk);
      `CHK(carry_in_used, k[0])
      `CHK(carry_out_update, k[1])
    end
    for (int k = 0; k < 8; k++) begin
      sel_size = k[2:0];
      @(negedge clk);
      `CHK(mem_size, (k > 5) ? BOD_SZ_WORD : bod_size_t'(k[2:0]))
      `CHK(mem_signed, !(k == 2 || k == 4))
    end
    sel_user = 1'b1;
    @(negedge clk);
    `CHK(user_space_access, 1'b0)
    supervisor = 1'b1;
    field_width = 5'h0;
    sel_fp_double = 3'h5;
    dest_field = 5'h1B;
    first_source_reg = 32'h0000_0001;
    immediate_index = 16'h8000;
    @(negedge clk);
    `CHK(user_space_access, 1'b1)
    `CHK(field_width_eff, 6'h20)
    `CHK(fp_double, 3'h5)
    `CHK(store_src_reg, 5'h1B)
    `CHK(mem_address, 32'h0000_8001)
    $display("qualifier test done");
  endtask

  // Print counts and verdict, then stop
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Main sequence after four reset cycles
  initial begin
    repeat (4) @(negedge clk);
    reset_n = 1'b1;
    @(negedge clk);
    t_bit();
    t_cond();
    t_trap();
    t_long();
    t_qual();
    end_of_test();
  end

  // Hang guard, far beyond the roughly 140 cycles needed
  initial begin
    #1000000;
    n_errors++;
    end_of_test();
  end
endmodule
`default_nettype wire
